// *** core/gpio_pkg.sv ***
/*
 gpio_pkg: register offsets, field positions, reset values and counts
 shared by the port block. Assumes a 32-bit Avalon-MM slave, word addressed
 by byte address.
*/
package gpio_pkg;
	// -----------------------------------------------------------------
	// register byte offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] PORT0_OFS       = 8'h00;
	localparam logic [7:0] PORT1_OFS       = 8'h04;
	localparam logic [7:0] PORT0_DRIVE_OFS = 8'h08;
	localparam logic [7:0] PORT1_DRIVE_OFS = 8'h0c;
	localparam logic [7:0] OPTION_CTRL_OFS = 8'h10;
	localparam logic [7:0] SPECIAL_SET_OFS = 8'h14;
	localparam logic [7:0] STATUS_OFS      = 8'h18;
	// -----------------------------------------------------------------
	// option control fields
	// -----------------------------------------------------------------
	localparam int LED_LO_BIT      = 0;
	localparam int LED_HI_BIT      = 1;
	localparam int ROFF_BIT        = 5;
	localparam int MATRIX_BIT      = 6;
	localparam int STROBE_BIT      = 7;
	// -----------------------------------------------------------------
	// special role fields
	// -----------------------------------------------------------------
	localparam int REFEN_BIT       = 0;
	localparam int CLKEN_BIT       = 1;
	localparam int CLKOUT0_BIT     = 2;
	localparam int CLKOUT1_BIT     = 3;
	localparam int XO_EN_BIT       = 4;
	// -----------------------------------------------------------------
	// status fields
	// -----------------------------------------------------------------
	localparam int WAKE_BIT        = 0;
	localparam int DEBUG_BIT       = 1;
	localparam int LED_ON_BIT      = 2;
	// -----------------------------------------------------------------
	// reset values and package counts
	// -----------------------------------------------------------------
	localparam logic [7:0] PORT0_RESET = 8'hff;
	localparam logic [1:0] PORT1_RESET = 2'h3;
	localparam logic [7:0] DRIVE0_RESET = 8'h00;
	localparam logic [1:0] DRIVE1_RESET = 2'h0;
	localparam int SMALL_PINS      = 6;
	localparam int LARGE_PINS      = 10;
	localparam int SYNC_STAGES     = 3;
endpackage

// *** core/pin_sync.sv ***
/*
 pin_sync: three-stage synchroniser per pin; a change is accepted once the
 second and third stages agree. Assumes asynchronous pin inputs.
*/
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 10
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	// -----------------------------------------------------------------
	// stages per bit
	// -----------------------------------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				s1_q[i]  <= 1'b1;
				s2_q[i]  <= 1'b1;
				s3_q[i]  <= 1'b1;
				level[i] <= 1'b1;
			end else begin
				s1_q[i] <= pin_in[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (s2_q[i] == s3_q[i]) begin
					level[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

// *** core/gpio_port.sv ***
/*
 gpio_port: port pins with drive select, special roles, pad option latch
 and shutdown wake. Assumes an Avalon-MM master and pads that turn the
 output, enable, pullup and pulldown signals into pin levels.
*/
`timescale 1ns/10ps
// Operation
// R1: small package has six pins, the low six bits of port zero
// R2: large package has ten pins, port zero plus two bits of port one
// R3: each pin chooses open-drain or push-pull by its drive select bit
// R4: matrix and pullup-disable options exist only on pins one to three
// R5: pin zero is input only, driver off, may feed the crystal input
// R6: pin five is only a current LED driver of at most 1mA
// R7: LED driver is off while a debug session is active
// R8: clock output enabled separately on pins four and six, both allowed
// R9: latched pullup-disable disconnects the weak pullups
// R10: pullup-disable is held in the pad latch through shutdown
// R11: in shutdown any pin pulled low wakes the chip
// R12: with matrix latched, pins one to three drive low in shutdown
// R13: software keeps pullup-disable clear when using matrix
// R14: latched matrix cuts pullups and enables pulldowns on pins one to three
// R15: software makes pins one to three inputs before enabling matrix
// R16: software turns matrix off after wake before scanning
// R17: software scans rows with patterns 110, 101, 111 open-drain
// R18: software reads columns on pins four, zero and nine to six
// R19: matrix is three rows by two or six columns
// R20: pin three routes reference clock to frequency counter when enabled
// R21: in development pin five is debug clock, pin four debug data
// R22: option latch captures matrix and pullup-disable on strobe rise then fall
// R23: option reads return the latched pad values, not pending writes
// R24: input port bits read the synchronized pin level
module gpio_port #(
	parameter bit LARGE_PKG = 1'b1
) (
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic [4:0]  ADDRESS,
	input  wire logic        READ,
	input  wire logic        WRITE,
	input  wire logic [3:0]  BYTEENABLE,
	input  wire logic [31:0] WRITEDATA,
	output logic      [31:0] READDATA,
	output logic             WAITREQUEST,
	input  wire logic [9:0]  PIN_IN,
	output logic      [9:0]  PIN_OUT,
	output logic      [9:0]  PIN_OE,
	output logic      [9:0]  PULLUP_EN,
	output logic      [9:0]  PULLDOWN_EN,
	input  wire logic        SHUTDOWN,
	input  wire logic        DEBUG_ACTIVE,
	input  wire logic        DEBUG_CLK_OUT,
	input  wire logic        DEBUG_CLK_OE,
	input  wire logic        DEBUG_DATA_OUT,
	input  wire logic        DEBUG_DATA_OE,
	input  wire logic        CLK_OUT_SRC,
	output logic             WAKE,
	output logic             LED_SINK_EN,
	output logic             CLK_REF,
	output logic             CRYSTAL_OSCILLATOR_INPUT,
	output logic             DEBUG_CLOCK_PIN,
	output logic             DEBUG_DATA_PIN
);
	localparam int NPINS = LARGE_PKG ? gpio_pkg::LARGE_PINS : gpio_pkg::SMALL_PINS;
	localparam logic [9:0] PIN_MASK = 10'((1 << NPINS) - 1); // R1 R2

	logic [7:0]  port0_q;
	logic [1:0]  port1_q;
	logic [7:0]  port0_drive_select_q;
	logic [1:0]  port1_drive_select_q;
	logic [7:0]  opt_ctrl_q;
	logic [4:0]  special_q;
	logic        pad_matrix_q;
	logic        pad_roff_q;
	logic        ack_q;
	logic [9:0]  level;
	logic [9:0]  port_val;
	logic [9:0]  drive_pp;
	logic [9:0]  out_d;
	logic [9:0]  oe_d;
	logic [9:0]  pu_d;
	logic [9:0]  pd_d;
	logic [31:0] rdata_d;
	logic [7:0]  wbyte;
	logic        wr_go;
	logic        clkout_en4;
	logic        clkout_en6;
	logic        led_d;
	logic [9:0]  wake_src;

	// -----------------------------------------------------------------
	// pin synchroniser
	// -----------------------------------------------------------------
	pin_sync #(
		.WIDTH (10)
	) u_sync (
		.clk    (CLK),
		.rstn   (RSTN),
		.pin_in (PIN_IN),
		.level  (level)
	);

	// -----------------------------------------------------------------
	// bus handshake: one wait cycle per access
	// -----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (READ || WRITE) && !ack_q;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			WAITREQUEST <= 1'b1;
		end else begin
			WAITREQUEST <= !((READ || WRITE) && !ack_q);
		end
	end

	assign wr_go = WRITE && ack_q && BYTEENABLE[0];
	assign wbyte = WRITEDATA[7:0];

	// -----------------------------------------------------------------
	// port value and drive select registers
	// -----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			port0_q <= gpio_pkg::PORT0_RESET;
			port1_q <= gpio_pkg::PORT1_RESET;
		end else if (wr_go && {3'h0, ADDRESS} == gpio_pkg::PORT0_OFS) begin
			port0_q <= wbyte & PIN_MASK[7:0];
		end else if (wr_go && {3'h0, ADDRESS} == gpio_pkg::PORT1_OFS) begin
			port1_q <= wbyte[1:0] & PIN_MASK[9:8];
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			port0_drive_select_q <= gpio_pkg::DRIVE0_RESET;
			port1_drive_select_q <= gpio_pkg::DRIVE1_RESET;
		end else if (wr_go && {3'h0, ADDRESS} == gpio_pkg::PORT0_DRIVE_OFS) begin
			port0_drive_select_q <= wbyte & PIN_MASK[7:0]; // R3
		end else if (wr_go && {3'h0, ADDRESS} == gpio_pkg::PORT1_DRIVE_OFS) begin
			port1_drive_select_q <= wbyte[1:0] & PIN_MASK[9:8]; // R3
		end
	end

	// -----------------------------------------------------------------
	// option control and special roles
	// -----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			opt_ctrl_q <= 8'h00;
		end else if (wr_go && {3'h0, ADDRESS} == gpio_pkg::OPTION_CTRL_OFS) begin
			opt_ctrl_q <= wbyte;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			special_q <= 5'h00;
		end else if (wr_go && {3'h0, ADDRESS} == gpio_pkg::SPECIAL_SET_OFS) begin
			special_q <= wbyte[4:0];
		end
	end

	// -----------------------------------------------------------------
	// pad option latch, loaded on strobe falling after a rise
	// -----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pad_matrix_q <= 1'b0;
			pad_roff_q   <= 1'b0;
		end else if (wr_go && {3'h0, ADDRESS} == gpio_pkg::OPTION_CTRL_OFS
			&& opt_ctrl_q[gpio_pkg::STROBE_BIT] && !wbyte[gpio_pkg::STROBE_BIT]) begin
			pad_matrix_q <= opt_ctrl_q[gpio_pkg::MATRIX_BIT]; // R22 R10
			pad_roff_q   <= opt_ctrl_q[gpio_pkg::ROFF_BIT]; // R22 R10
		end
	end

	// -----------------------------------------------------------------
	// pin drive composition
	// -----------------------------------------------------------------
	assign port_val   = {port1_q, port0_q};
	assign drive_pp   = {port1_drive_select_q, port0_drive_select_q};
	assign clkout_en4 = special_q[gpio_pkg::CLKEN_BIT] && special_q[gpio_pkg::CLKOUT0_BIT]; // R8
	assign clkout_en6 = special_q[gpio_pkg::CLKEN_BIT] && special_q[gpio_pkg::CLKOUT1_BIT]; // R8
	assign led_d      = !DEBUG_ACTIVE && !port0_q[5]
		&& (opt_ctrl_q[gpio_pkg::LED_HI_BIT:gpio_pkg::LED_LO_BIT] != 2'h0); // R6 R7

	always_comb begin
		out_d = 10'h000;
		oe_d  = 10'h000;
		pu_d  = PIN_MASK;
		pd_d  = 10'h000;
		for (int i = 0; i < 10; i++) begin
			// push-pull drives both levels, open-drain only low
			out_d[i] = port_val[i];
			oe_d[i]  = PIN_MASK[i] && (drive_pp[i] || !port_val[i]); // R3
		end
		oe_d[0]  = 1'b0; // R5
		out_d[5] = 1'b0;
		oe_d[5]  = 1'b0; // R6
		if (special_q[gpio_pkg::REFEN_BIT]) begin
			oe_d[3] = 1'b0; // R20
		end
		if (clkout_en4) begin
			out_d[4] = CLK_OUT_SRC;
			oe_d[4]  = 1'b1; // R8
		end
		if (clkout_en6 && LARGE_PKG) begin
			out_d[6] = CLK_OUT_SRC;
			oe_d[6]  = 1'b1; // R8
		end
		if (DEBUG_ACTIVE) begin
			out_d[5] = DEBUG_CLK_OUT;
			oe_d[5]  = DEBUG_CLK_OE; // R21
			out_d[4] = DEBUG_DATA_OUT;
			oe_d[4]  = DEBUG_DATA_OE; // R21
		end
		if (pad_roff_q) begin
			pu_d[3:1] = 3'h0; // R9 R4
		end
		if (pad_matrix_q) begin
			pu_d[3:1] = 3'h0; // R14 R4
			pd_d[3:1] = 3'h7; // R14
		end
		if (SHUTDOWN) begin
			oe_d  = 10'h000;
			out_d = 10'h000;
			if (pad_matrix_q) begin
				oe_d[3:1] = 3'h7; // R12 R19
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			PIN_OUT     <= 10'h000;
			PIN_OE      <= 10'h000;
			PULLUP_EN   <= 10'h3ff;
			PULLDOWN_EN <= 10'h000;
		end else begin
			PIN_OUT     <= out_d;
			PIN_OE      <= oe_d;
			PULLUP_EN   <= pu_d;
			PULLDOWN_EN <= pd_d;
		end
	end

	// -----------------------------------------------------------------
	// special role outputs and wake
	// -----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			LED_SINK_EN              <= 1'b0;
			CLK_REF                  <= 1'b0;
			CRYSTAL_OSCILLATOR_INPUT <= 1'b0;
			DEBUG_CLOCK_PIN          <= 1'b0;
			DEBUG_DATA_PIN           <= 1'b0;
		end else begin
			LED_SINK_EN              <= led_d && !SHUTDOWN; // R6 R7
			CLK_REF                  <= special_q[gpio_pkg::REFEN_BIT] && level[3]; // R20
			CRYSTAL_OSCILLATOR_INPUT <= special_q[gpio_pkg::XO_EN_BIT] && level[0]; // R5
			DEBUG_CLOCK_PIN          <= level[5]; // R21
			DEBUG_DATA_PIN           <= level[4]; // R21
		end
	end

	// rows held low by the pad itself never count as a press
	assign wake_src = ~level & PIN_MASK & (pad_matrix_q ? 10'h3f1 : 10'h3ff); // R12

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			WAKE <= 1'b0;
		end else begin
			WAKE <= SHUTDOWN && (wake_src != 10'h000); // R11 R19
		end
	end

	// -----------------------------------------------------------------
	// read mux
	// -----------------------------------------------------------------
	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case ({3'h0, ADDRESS})
			gpio_pkg::PORT0_OFS: rdata_d[7:0] = level[7:0] & PIN_MASK[7:0]; // R24
			gpio_pkg::PORT1_OFS: rdata_d[1:0] = level[9:8] & PIN_MASK[9:8]; // R24
			gpio_pkg::PORT0_DRIVE_OFS: rdata_d[7:0] = port0_drive_select_q;
			gpio_pkg::PORT1_DRIVE_OFS: rdata_d[1:0] = port1_drive_select_q;
			gpio_pkg::OPTION_CTRL_OFS: begin
				rdata_d[7:0] = opt_ctrl_q;
				rdata_d[gpio_pkg::MATRIX_BIT] = pad_matrix_q; // R23
				rdata_d[gpio_pkg::ROFF_BIT]   = pad_roff_q; // R23
			end
			gpio_pkg::SPECIAL_SET_OFS: rdata_d[4:0] = special_q;
			gpio_pkg::STATUS_OFS: begin
				rdata_d[gpio_pkg::WAKE_BIT]   = WAKE;
				rdata_d[gpio_pkg::DEBUG_BIT]  = DEBUG_ACTIVE;
				rdata_d[gpio_pkg::LED_ON_BIT] = LED_SINK_EN;
			end
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			READDATA <= 32'h0000_0000;
		end else if (READ && !ack_q) begin
			READDATA <= rdata_d;
		end
	end
endmodule

// *** tb/gpio_port_checker.sv ***
/*
 gpio_port_checker: port-level properties of the port block.
 assumes it is bound to gpio_port and sees only its ports.
*/
`timescale 1ns/10ps
module gpio_port_checker (
	input wire logic       CLK,
	input wire logic       RSTN,
	input wire logic       READ,
	input wire logic       WRITE,
	input wire logic       WAITREQUEST,
	input wire logic [9:0] PIN_IN,
	input wire logic [9:0] PIN_OUT,
	input wire logic [9:0] PIN_OE,
	input wire logic [9:0] PULLUP_EN,
	input wire logic [9:0] PULLDOWN_EN,
	input wire logic       SHUTDOWN,
	input wire logic       DEBUG_ACTIVE,
	input wire logic       WAKE,
	input wire logic       LED_SINK_EN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	chk_pin0_no_drive:
		assert property (!PIN_OE[0]) else $error("pin zero driven");
	chk_pin5_led_only:
		assert property (!DEBUG_ACTIVE && !$past(DEBUG_ACTIVE) |-> !PIN_OE[5])
		else $error("pin five driven");
	chk_led_debug_off:
		assert property (DEBUG_ACTIVE && $past(DEBUG_ACTIVE) |-> !LED_SINK_EN)
		else $error("led on in debug");
	chk_wake_in_sd:
		assert property (WAKE |-> $past(SHUTDOWN)) else $error("wake outside shutdown");
	chk_wake_on_low:
		assert property ((SHUTDOWN && !PIN_IN[9]) [*7] |-> WAKE)
		else $error("no wake on low pin");
	chk_matrix_rows_low:
		assert property (SHUTDOWN && $past(SHUTDOWN) && PULLDOWN_EN[1]
			|-> PIN_OE[3:1] == 3'h7 && PIN_OUT[3:1] == 3'h0) else $error("rows not low");
	chk_pulldown_group:
		assert property (PULLDOWN_EN[1] |-> PULLDOWN_EN[3:1] == 3'h7 && PULLUP_EN[3:1] == 3'h0)
		else $error("matrix pulls wrong");
	chk_fixed_pulls:
		assert property (PULLDOWN_EN[0] == 1'b0 && PULLDOWN_EN[9:4] == 6'h00)
		else $error("pulldown outside rows");
	chk_wait_pulse:
		assert property (!WAITREQUEST |=> WAITREQUEST) else $error("wait low too long");
	chk_wait_answer:
		assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
		else $error("no answer");
	chk_wait_idle:
		assert property (!READ && !WRITE && WAITREQUEST |=> WAITREQUEST)
		else $error("answer without request");
endmodule
bind gpio_port gpio_port_checker chk (.CLK(CLK), .RSTN(RSTN), .READ(READ), .WRITE(WRITE),
	.WAITREQUEST(WAITREQUEST), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
	.PULLUP_EN(PULLUP_EN), .PULLDOWN_EN(PULLDOWN_EN), .SHUTDOWN(SHUTDOWN),
	.DEBUG_ACTIVE(DEBUG_ACTIVE), .WAKE(WAKE), .LED_SINK_EN(LED_SINK_EN));

// *** tb/pin_partner.sv ***
/*
 pin_partner: buttons to ground, one matrix key and pad pulls.
 assumes the pad drive and pull signals of the port block.
*/
`timescale 1ns/10ps
module pin_partner (
	input  wire logic       clk,
	input  wire logic [9:0] pin_out,
	input  wire logic [9:0] pin_oe,
	input  wire logic [9:0] pullup_en,
	input  wire logic [9:0] pulldown_en,
	input  wire logic [9:0] button,
	input  wire logic       matrix_key,
	output logic      [9:0] pin_in
);
	logic toggle_q = 1'b0;
	always @(posedge clk) toggle_q <= ~toggle_q;
	always_comb begin
		for (int i = 0; i < 10; i++) begin
			if (pin_oe[i]) pin_in[i] = pin_out[i];
			else if (button[i] || pulldown_en[i]) pin_in[i] = 1'b0;
			else if (pullup_en[i]) pin_in[i] = 1'b1;
			else pin_in[i] = toggle_q ^ i[0];
		end
		// key joins row two to column four
		if (matrix_key && !pin_in[2] && !pin_oe[4]) pin_in[4] = 1'b0;
	end
endmodule

// *** tb/gpio_port_matrix_wake_tb.sv ***
/*
 gpio_port_matrix_wake_tb: self-checking bench of the port block.
 assumes a 250 MHz clock and the pin partner model.
*/
`timescale 1ns/10ps
module gpio_port_matrix_wake_tb;
	typedef struct {logic [4:0] a; logic [3:0] b; logic [7:0] w; logic [9:0] e;} row_t;
	logic        clk, rstn, rd, wr, sd, dbg, dbg_oe, clk_src, key, waitreq;
	logic        wake, led, cref, osc_in, dclk, ddat;
	logic [4:0]  addr;
	logic [3:0]  be;
	logic [31:0] wdata, rdata;
	logic [9:0]  pin_in, pin_out, pin_oe, pu, pd, btn, rv, pu_s, oe_s;
	int          num_errors, num_checks;
	row_t        rows [8] = '{'{5'h08, 4'h0, 8'hff, 10'h000}, '{5'h0c, 4'h0, 8'hff, 10'h000},
		'{5'h10, 4'h0, 8'hff, 10'h000}, '{5'h08, 4'h1, 8'ha5, 10'h0a5},
		'{5'h0c, 4'h1, 8'hff, 10'h003}, '{5'h1c, 4'h1, 8'hff, 10'h000},
		'{5'h10, 4'h1, 8'h63, 10'h003}, '{5'h14, 4'h1, 8'h0f, 10'h00f}};
	logic [7:0]  scan [3] = '{8'hfd, 8'hfb, 8'hff};
	gpio_port uut (.CLK(clk), .RSTN(rstn), .ADDRESS(addr), .READ(rd), .WRITE(wr),
		.BYTEENABLE(be), .WRITEDATA(wdata), .READDATA(rdata), .WAITREQUEST(waitreq),
		.PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULLUP_EN(pu),
		.PULLDOWN_EN(pd), .SHUTDOWN(sd), .DEBUG_ACTIVE(dbg), .DEBUG_CLK_OUT(clk_src),
		.DEBUG_CLK_OE(dbg_oe), .DEBUG_DATA_OUT(1'b0), .DEBUG_DATA_OE(dbg_oe),
		.CLK_OUT_SRC(clk_src), .WAKE(wake), .LED_SINK_EN(led), .CLK_REF(cref),
		.CRYSTAL_OSCILLATOR_INPUT(osc_in), .DEBUG_CLOCK_PIN(dclk), .DEBUG_DATA_PIN(ddat));
	// small package copy on the same bus; its upper pins read high
	gpio_port #(.LARGE_PKG(1'b0)) uut_small (.CLK(clk), .RSTN(rstn), .ADDRESS(addr),
		.READ(rd), .WRITE(wr), .BYTEENABLE(be), .WRITEDATA(wdata), .READDATA(),
		.WAITREQUEST(), .PIN_IN(pin_in | 10'h3c0), .PIN_OUT(), .PIN_OE(oe_s),
		.PULLUP_EN(pu_s), .PULLDOWN_EN(), .SHUTDOWN(sd), .DEBUG_ACTIVE(dbg),
		.DEBUG_CLK_OUT(clk_src), .DEBUG_CLK_OE(dbg_oe), .DEBUG_DATA_OUT(1'b0),
		.DEBUG_DATA_OE(dbg_oe), .CLK_OUT_SRC(clk_src), .WAKE(), .LED_SINK_EN(),
		.CLK_REF(), .CRYSTAL_OSCILLATOR_INPUT(), .DEBUG_CLOCK_PIN(), .DEBUG_DATA_PIN());
	pin_partner dev (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pu),
		.pulldown_en(pd), .button(btn), .matrix_key(key), .pin_in(pin_in));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] b);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= {24'h0, d};
		be <= b;
		do @(posedge clk); while (waitreq !== 1'b0);
		rv = {1'b0, |rdata[31:8], rdata[7:0]};
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		num_errors++;
		results();
	end
	initial begin
		{rstn, rd, wr, sd, dbg, dbg_oe, clk_src, key} = 8'h00;
		addr = 5'h00;
		be = 4'h0;
		wdata = 32'h0;
		btn = 10'h000;
		cyc(8);
		check("pullups", pu, 10'h3ff);
		rstn <= 1'b1;
		cyc(1);
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].w, rows[i].b);
			bus(1'b0, rows[i].a, 8'h00, 4'hf);
			check("reg", rv, rows[i].e);
		end
		check("small pu", pu_s, 10'h03f);
		check("small oe", oe_s & 10'h3c0, 10'h000);
		check("large oe", pin_oe & 10'h380, 10'h380);
		clk_src <= 1'b1;
		bus(1'b1, 5'h14, 8'h0e, 4'h1);
		cyc(4);
		check("clkout", pin_out & pin_oe & 10'h050, 10'h050);
		bus(1'b1, 5'h14, 8'h00, 4'h1);
		bus(1'b1, 5'h08, 8'h80, 4'h1);
		bus(1'b1, 5'h00, 8'hbf, 4'h1);
		cyc(8);
		check("oe", pin_oe & 10'h0c0, 10'h0c0);
		bus(1'b0, 5'h00, 8'h00, 4'hf);
		check("p0", rv & 10'h0c0, 10'h080);
		bus(1'b1, 5'h00, 8'hff, 4'h1);
		bus(1'b1, 5'h08, 8'h00, 4'h1);
		bus(1'b1, 5'h14, 8'h11, 4'h1);
		btn <= 10'h009;
		cyc(8);
		check("low", {8'h0, osc_in, cref}, 10'h000);
		btn <= 10'h000;
		cyc(8);
		check("high", {8'h0, osc_in, cref}, 10'h003);
		bus(1'b1, 5'h10, 8'h01, 4'h1);
		bus(1'b1, 5'h00, 8'hdf, 4'h1);
		cyc(4);
		check("led", {9'h0, led}, 10'h001);
		dbg <= 1'b1;
		dbg_oe <= 1'b1;
		cyc(8);
		check("led", {9'h0, led}, 10'h000);
		check("dbg", pin_oe & (pin_out ^ 10'h010) & 10'h030, 10'h030);
		check("dbgin", {8'h0, dclk, ddat}, 10'h002);
		{dbg, dbg_oe} <= 2'h0;
		bus(1'b1, 5'h00, 8'hff, 4'h1);
		sd <= 1'b1;
		cyc(8);
		check("wake", {9'h0, wake}, 10'h000);
		btn <= 10'h200;
		cyc(8);
		check("wake", {9'h0, wake}, 10'h001);
		{sd, btn} <= 11'h000;
		bus(1'b1, 5'h10, 8'h20, 4'h1);
		cyc(3);
		check("pu", pu, 10'h3ff);
		bus(1'b1, 5'h10, 8'ha0, 4'h1);
		bus(1'b1, 5'h10, 8'h20, 4'h1);
		sd <= 1'b1;
		cyc(4);
		check("pu", pu & 10'h00e, 10'h000);
		sd <= 1'b0;
		bus(1'b1, 5'h10, 8'h40, 4'h1);
		bus(1'b0, 5'h10, 8'h00, 4'hf);
		check("opt", rv, 10'h020);
		bus(1'b1, 5'h10, 8'hc0, 4'h1);
		bus(1'b1, 5'h10, 8'h40, 4'h1);
		cyc(3);
		check("pd", pd, 10'h00e);
		sd <= 1'b1;
		cyc(8);
		check("wake", {9'h0, wake}, 10'h000);
		key <= 1'b1;
		cyc(8);
		check("rows", pin_oe & ~pin_out & 10'h00e, 10'h00e);
		check("wake", {9'h0, wake}, 10'h001);
		sd <= 1'b0;
		bus(1'b1, 5'h10, 8'h80, 4'h1);
		bus(1'b1, 5'h10, 8'h00, 4'h1);
		cyc(3);
		check("pd", pd, 10'h000);
		foreach (scan[i]) begin
			bus(1'b1, 5'h00, scan[i], 4'h1);
			cyc(6);
			bus(1'b0, 5'h00, 8'h00, 4'hf);
			check("col", rv & 10'h011, {5'h0, scan[i][2], 4'h1});
		end
		results();
	end
endmodule
